/* File: core/pid_pkg.sv */
package pid_pkg;

   // ****************************************
   // leaf numbers and index limits
   // ****************************************
   localparam logic [31:0] PID_LEAF_VENDOR = 32'h0000_0000; // maximum leaf and vendor string
   localparam logic [31:0] PID_LEAF_VERSION = 32'h0000_0001; // version and brand
   localparam logic [31:0] PID_LEAF_TLB = 32'h0000_0002; // cache and tlb descriptors
   localparam logic [31:0] PID_LEAF_SERIAL = 32'h0000_0003; // serial number
   localparam logic [31:0] PID_LEAF_CACHE = 32'h0000_0004; // deterministic cache parameters
   localparam logic [31:0] PID_LEAF_MONITOR = 32'h0000_0005; // monitor/wait
   localparam logic [31:0] PID_LEAF_THERMAL = 32'h0000_0006; // thermal and power
   localparam logic [31:0] PID_EXT_BASE = 32'h8000_0000; // first extended leaf
   localparam logic [31:0] PID_LEGACY_MAX = 32'h0000_0003; // highest leaf under the legacy limit

   // ****************************************
   // field positions
   // ****************************************
   localparam int PID_LEGACY_BIT = 22; // legacy_os_leaf_limit in misc_feature_enable_reg
   localparam int PID_MT_BIT = 28; // multi_thread_flag in word d of leaf one
   localparam logic [31:0] PID_THERM_A_MASK = 32'h0000_2ef5; // defined feature bits of leaf six word a
   localparam logic [4:0] PID_CTYPE_NULL = 5'h00; // no more caches
   localparam logic [4:0] PID_CTYPE_DATA = 5'h01; // data cache
   localparam logic [4:0] PID_CTYPE_INSN = 5'h02; // instruction cache
   localparam logic [4:0] PID_CTYPE_UNIF = 5'h03; // unified cache

   // ****************************************
   // register bus map and reset values
   // ****************************************
   localparam logic [11:0] PID_OFF_MISC = 12'h000; // misc_feature_enable_reg
   localparam logic [11:0] PID_OFF_STAT = 12'h004; // status: busy and answered count
   localparam logic PID_MISC_RESET = 1'b0; // legacy limit off by default
   localparam int PID_STAT_BUSY_BIT = 31; // busy flag inside status

   // ****************************************
   // timing
   // ****************************************
   localparam int PID_RESP_LATENCY = 2; // edges from request taken to valid

   // ****************************************
   // cache hierarchy reported by leaf four
   // ****************************************
   localparam int PID_CACHE_LEVELS = 3; // real caches before the null entry
   localparam logic [5:0] PID_CORE_IDS = 6'h03; // same for every valid sub-leaf
   localparam logic [11:0] PID_SHARE_IDS = 12'h001; // logical ids sharing each cache, minus one

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      PID_IDLE = 2'b00,
      PID_LOOK = 2'b01,
      PID_RESP = 2'b11
   } pid_state_t;

   typedef struct packed {
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic [31:0] d;
   } pid_quad_t;

   typedef struct packed {
      logic [31:0] leaf;
      logic [31:0] subleaf;
   } pid_req_t;

   typedef struct packed {
      pid_state_t state;
      pid_req_t req;
      logic [31:0] eff;
      pid_quad_t words;
      logic valid;
      logic legacy;
      logic [15:0] count;
      logic [31:0] prdata;
   } pid_regs_t;

   // builds one cache descriptor: type and level as given; ways, partitions, line, sets stored minus one
   function automatic pid_quad_t pid_cache_desc(input logic [31:0] idx);
      pid_quad_t q;
      logic [4:0] ctype;
      logic [2:0] lvl;
      logic [9:0] ways;
      logic [31:0] sets;
      q = '0;
      ctype = PID_CTYPE_NULL;
      lvl = 3'h0;
      ways = 10'h000;
      sets = 32'h0000_0000;
      unique case (idx)
         32'h0000_0000: begin
            ctype = PID_CTYPE_DATA;
            lvl = 3'h1;
            ways = 10'h007;
            sets = 32'h0000_003f;
         end
         32'h0000_0001: begin
            ctype = PID_CTYPE_INSN;
            lvl = 3'h1;
            ways = 10'h003;
            sets = 32'h0000_003f;
         end
         32'h0000_0002: begin
            ctype = PID_CTYPE_UNIF;
            lvl = 3'h2;
            ways = 10'h00f;
            sets = 32'h0000_01ff;
         end
         default: begin
            ctype = PID_CTYPE_NULL;
         end
      endcase
      if (ctype != PID_CTYPE_NULL) begin
         q.a = {PID_CORE_IDS, PID_SHARE_IDS, 4'h0, 1'b0, 1'b1, lvl, ctype};
         q.b = {ways, 10'h000, 12'h03f};
         q.c = sets;
         q.d = {29'h0, 1'b0, (ctype == PID_CTYPE_UNIF), 1'b0};
      end
      return q;
   endfunction

endpackage

/* File: core/pid_cache_rom.sv */
`timescale 1ns/100ps
// ****************************************
// cache descriptor table, registered read
// ****************************************
module pid_cache_rom
   import pid_pkg::*;
#(
   parameter int DEPTH = 4 // valid sub-leaves, null entry included
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [31:0] addr,
   output pid_quad_t rd_q
);

   pid_quad_t rd_d; // next read word

   // past the table every index is invalid and reads as zero
   always_comb begin
      if (addr < 32'(DEPTH)) begin
         rd_d = pid_cache_desc(addr);
      end else begin
         rd_d = '0;
      end
   end

   // read data leaves through a register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

endmodule

/* File: core/pid_responder.sv */
`timescale 1ns/100ps
// Notes on behaviour
// R1 - beyond range returns highest basic leaf
// R2 - unimplemented leaf in range returns zeros
// R3 - upper halves of wide results cleared
// R4 - substituted leaf still uses given sub-leaf
// R5 - any privilege; busy until result lands
// R6 - leaf zero: max leaf, vendor string
// R7 - leaf one word b field layout
// R8 - logical id field valid with thread flag
// R9 - leaf three serial only when present
// R10 - legacy limit hides leaves above three
// R11 - cache type code in bits four-zero
// R12 - cache word a level, flags, id fields
// R13 - ways, partitions, line, sets minus one
// R14 - cache word d three flags only
// R15 - sub-leaf after null entry returns zeros
// R16 - core id field same every sub-leaf
// R17 - monitor line sizes, upper halves zero
// R18 - monitor word c two flags
// R19 - monitor word d eight sub-state nibbles
// R20 - thermal word a feature flags
// R21 - thermal word b threshold count
// R22 - thermal word c feedback, bias flags
// R23 - strobe in, one valid pulse later
module pid_responder
   import pid_pkg::*;
#(
   parameter logic [31:0] MAX_BASIC = 32'h0000_000b, // highest basic leaf
   parameter logic [31:0] MAX_EXT = 32'h8000_0008, // highest extended leaf
   parameter logic [31:0] VENDOR_B = 32'h7475_654e, // arbitrary vendor text
   parameter logic [31:0] VENDOR_D = 32'h436c_6172, // arbitrary vendor text
   parameter logic [31:0] VENDOR_C = 32'h2165_726f, // arbitrary vendor text
   parameter logic [31:0] VERSION_INFO = 32'h0000_0001, // arbitrary version word
   parameter logic [7:0] BRAND_INDEX = 8'h00,
   parameter logic [7:0] FLUSH_LINE = 8'h08, // flush line size in 8-byte units
   parameter logic [7:0] LOGICAL_IDS = 8'h02,
   parameter logic [7:0] INITIAL_APIC_ID = 8'h00,
   parameter logic MULTI_THREAD_FLAG = 1'b1,
   parameter logic [31:0] FEATURE_C = 32'h0000_0000,
   parameter logic [31:0] FEATURE_D = 32'h0000_0000,
   parameter logic [127:0] CACHE_TLB = 128'h0,
   parameter logic SERIAL_NUMBER_FEATURE = 1'b0,
   parameter logic [63:0] SERIAL_LOW = 64'h0,
   parameter logic [15:0] MON_LINE_MIN = 16'h0040,
   parameter logic [15:0] MON_LINE_MAX = 16'h0040,
   parameter logic MON_EXT = 1'b1,
   parameter logic MON_BREAK = 1'b1,
   parameter logic [31:0] MON_SUBSTATES = 32'h0000_2220,
   parameter logic [31:0] THERM_FEATURES = 32'h0000_0005,
   parameter logic [3:0] THERM_THRESHOLDS = 4'h2,
   parameter logic PERF_FEEDBACK = 1'b1,
   parameter logic ENERGY_BIAS = 1'b1,
   parameter int CACHE_DEPTH = PID_CACHE_LEVELS + 1
) (
   input wire logic core_clk,
   input wire logic rstn,
   // query port from the execution pipeline
   input wire logic req_valid,
   input wire pid_req_t req,
   output logic req_ready,
   output logic busy,
   output logic resp_valid,
   output logic [63:0] wide_result_a,
   output logic [63:0] result_word_b,
   output logic [63:0] result_word_c,
   output logic [63:0] result_word_d,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ****************************************
   // state and helpers
   // ****************************************
   pid_regs_t st_q; // every flop of the block but the cache table read register
   pid_regs_t st_d; // next value
   pid_quad_t rom_q; // cache descriptor for the held sub-leaf
   logic [31:0] max_vis; // highest basic leaf software may see
   logic take; // request accepted this cycle
   logic apb_wr; // write completes this cycle
   logic apb_setup; // first cycle of a transfer

   // true for an address the slave answers
   function automatic logic pid_mapped(input logic [11:0] a);
      return (a == PID_OFF_MISC) || (a == PID_OFF_STAT);
   endfunction

   // out of range when past basic but below extended, or past extended
   function automatic logic [31:0] pid_effective(input logic [31:0] leaf, input logic [31:0] mb);
      if ((leaf > mb && leaf < PID_EXT_BASE) || leaf > MAX_EXT) begin
         return mb; // R1
      end
      return leaf;
   endfunction

   // ****************************************
   // cache table
   // ****************************************
   pid_cache_rom #(
      .DEPTH(CACHE_DEPTH)
   ) u_rom (
      .core_clk(core_clk),
      .rstn(rstn),
      .addr(st_q.req.subleaf),
      .rd_q(rom_q)
   );

   // legacy limit caps the visible range at three
   always_comb begin
      if (st_q.legacy && MAX_BASIC > PID_LEGACY_MAX) begin
         max_vis = PID_LEGACY_MAX; // R10
      end else begin
         max_vis = MAX_BASIC;
      end
   end

   assign take = req_valid && (st_q.state == PID_IDLE);
   assign apb_wr = psel && penable && pwrite && pid_mapped(paddr);
   assign apb_setup = psel && !penable;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      st_d.valid = 1'b0;
      unique case (st_q.state)
         // idle: accept at any privilege, nothing is checked
         PID_IDLE: begin
            if (take) begin
               st_d.req = req; // R4
               st_d.eff = pid_effective(req.leaf, max_vis); // R1
               st_d.state = PID_LOOK; // R5
            end
         end
         // look: cache table reads the held sub-leaf
         PID_LOOK: begin
            st_d.state = PID_RESP;
         end
         // resp: assemble the four words, one valid pulse
         PID_RESP: begin
            st_d.words = '0; // R2
            unique case (st_q.eff)
               PID_LEAF_VENDOR: begin
                  st_d.words.a = max_vis; // R6
                  st_d.words.b = VENDOR_B; // R6
                  st_d.words.d = VENDOR_D; // R6
                  st_d.words.c = VENDOR_C; // R6
               end
               PID_LEAF_VERSION: begin
                  st_d.words.a = VERSION_INFO;
                  // logical id field only carries meaning with the thread flag
                  st_d.words.b = {INITIAL_APIC_ID, (MULTI_THREAD_FLAG ? LOGICAL_IDS : 8'h01),
                                  FLUSH_LINE, BRAND_INDEX}; // R7 R8
                  st_d.words.c = FEATURE_C;
                  st_d.words.d = FEATURE_D | (32'(MULTI_THREAD_FLAG) << PID_MT_BIT); // R8
               end
               PID_LEAF_TLB: begin
                  st_d.words = CACHE_TLB;
               end
               PID_LEAF_SERIAL: begin
                  if (SERIAL_NUMBER_FEATURE) begin
                     st_d.words.c = SERIAL_LOW[31:0]; // R9
                     st_d.words.d = SERIAL_LOW[63:32]; // R9
                  end
               end
               PID_LEAF_CACHE: begin
                  // rom already zeroes invalid sub-leaves and the null entry
                  st_d.words = rom_q; // R11 R12 R13 R14 R15 R16
               end
               PID_LEAF_MONITOR: begin
                  st_d.words.a = {16'h0000, MON_LINE_MIN}; // R17
                  st_d.words.b = {16'h0000, MON_LINE_MAX}; // R17
                  st_d.words.c = {30'h0, MON_BREAK, MON_EXT}; // R18
                  st_d.words.d = MON_SUBSTATES; // R19
               end
               PID_LEAF_THERMAL: begin
                  st_d.words.a = THERM_FEATURES & PID_THERM_A_MASK; // R20
                  st_d.words.b = {28'h0, THERM_THRESHOLDS}; // R21
                  st_d.words.c = {28'h0, ENERGY_BIAS, 2'b00, PERF_FEEDBACK}; // R22
               end
               default: begin
                  st_d.words = '0; // R2
               end
            endcase
            st_d.valid = 1'b1; // R23
            st_d.count = st_q.count + 16'h0001;
            st_d.state = PID_IDLE;
         end
         default: begin
            st_d.state = PID_IDLE;
         end
      endcase
      // register bus: write the legacy limit, latch read data in setup
      if (apb_wr && paddr == PID_OFF_MISC) begin
         st_d.legacy = pwdata[PID_LEGACY_BIT]; // R10
      end
      if (apb_setup) begin
         st_d.prdata = '0;
         if (paddr == PID_OFF_MISC) begin
            st_d.prdata[PID_LEGACY_BIT] = st_q.legacy;
         end else if (paddr == PID_OFF_STAT) begin
            st_d.prdata[PID_STAT_BUSY_BIT] = (st_q.state != PID_IDLE);
            st_d.prdata[15:0] = st_q.count;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.state <= PID_IDLE;
         st_q.legacy <= PID_MISC_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign req_ready = (st_q.state == PID_IDLE);
   assign busy = (st_q.state != PID_IDLE); // R5
   assign resp_valid = st_q.valid;
   assign wide_result_a = {32'h0000_0000, st_q.words.a}; // R3
   assign result_word_b = {32'h0000_0000, st_q.words.b}; // R3
   assign result_word_c = {32'h0000_0000, st_q.words.c}; // R3
   assign result_word_d = {32'h0000_0000, st_q.words.d}; // R3
   assign prdata = st_q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !pid_mapped(paddr);

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_taken;
      req_valid && req_ready;
   endsequence
   sequence s_answer;
      !resp_valid [*2] ##1 resp_valid ##1 !resp_valid;
   endsequence

   a_resp_fixed_lat: assert property (s_taken |=> s_answer) // R23
      else $error("answer not on the second edge after the request");
   a_busy_window: assert property (s_taken |=> busy [*2] ##1 !busy) // R5
      else $error("busy does not cover the query");
   a_upper_clear: assert property (resp_valid |-> wide_result_a[63:32] == 32'h0 &&
      result_word_b[63:32] == 32'h0 && result_word_c[63:32] == 32'h0 && result_word_d[63:32] == 32'h0) // R3
      else $error("upper result half not clear");
   a_range_subst: assert property (req_valid && req_ready && req.leaf > max_vis && req.leaf < PID_EXT_BASE
      |=> st_q.eff == $past(max_vis) && st_q.req.subleaf == $past(req.subleaf)) // R1
      else $error("out of range leaf not replaced by highest basic leaf");
   a_legacy_hide: assert property (req_valid && req_ready && st_q.legacy && req.leaf == PID_LEAF_MONITOR
      |=> st_q.eff == PID_LEGACY_MAX) // R10
      else $error("legacy limit did not hide leaf five");
   a_unimpl_zero: assert property (resp_valid && st_q.eff > PID_LEAF_THERMAL
      |-> st_q.words == '0) // R2
      else $error("unimplemented leaf returned data");
   a_leaf0_max: assert property (resp_valid && st_q.eff == PID_LEAF_VENDOR
      |-> wide_result_a[31:0] == max_vis) // R6
      else $error("leaf zero does not report the maximum leaf");
   a_cache_fields: assert property (resp_valid && st_q.eff == PID_LEAF_CACHE && st_q.words.a[4:0] != 5'h00
      |-> st_q.words.a[31:26] == PID_CORE_IDS && st_q.words.a[4:0] <= PID_CTYPE_UNIF
      && st_q.words.d[31:3] == 29'h0) // R11 R14 R16
      else $error("cache descriptor fields wrong");
   a_cache_invalid: assert property (resp_valid && st_q.eff == PID_LEAF_CACHE
      && st_q.req.subleaf >= 32'(CACHE_DEPTH) |-> st_q.words == '0) // R15
      else $error("invalid cache sub-leaf returned data");
   a_monitor_upper: assert property (resp_valid && st_q.eff == PID_LEAF_MONITOR
      |-> st_q.words.a[31:16] == 16'h0 && st_q.words.b[31:16] == 16'h0 && st_q.words.c[31:2] == 30'h0) // R17
      else $error("monitor leaf upper bits not zero");

endmodule

/* File: verif/pid_core_model.sv */
`timescale 1ns/100ps
// ****************************************
// execution pipeline model issuing queries
// ****************************************
module pid_core_model
   import pid_pkg::*;
(
   input wire logic core_clk,
   input wire logic req_ready,
   input wire logic busy,
   input wire logic resp_valid,
   input wire logic [255:0] words,
   output logic req_valid,
   output pid_req_t req
);
   // idle pipeline at time zero
   initial begin
      req_valid = 1'b0;
      req = '0;
   end

   // one query: hold it until taken, then count edges up to the answer
   task automatic issue(input logic [31:0] leaf, input logic [31:0] sub, input bit linger,
                        output logic [255:0] got, output int lat, output int busy_cyc);
      int n;
      got = '0;
      lat = 99;
      busy_cyc = 0;
      req_valid <= 1'b1;
      req <= {leaf, sub};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      // a lingering strobe carries another leaf while the block is busy
      if (linger) begin
         req.leaf <= ~leaf;
      end else begin
         req_valid <= 1'b0;
         req <= ~{leaf, sub};
      end
      for (n = 1; n <= 20; n++) begin
         @(posedge core_clk);
         if (n == 1 && linger) begin
            req_valid <= 1'b0;
            req <= ~{leaf, sub};
         end
         if (busy === 1'b1) busy_cyc++;
         if (resp_valid === 1'b1) begin
            lat = n;
            got = words;
            break;
         end
      end
      // a refused strobe must not raise a second answer
      if (linger) begin
         repeat (4) begin
            @(posedge core_clk);
            if (resp_valid !== 1'b0) lat = 98;
         end
      end
   endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
   import pid_pkg::*;
   // ****************************************
   // constants and signals
   // ****************************************
   localparam logic [31:0] MAXB = 32'h0000_0006; // highest basic leaf for this run
   localparam logic [31:0] VB = 32'h1234_5678; // arbitrary vendor text
   localparam logic [31:0] VD = 32'h9abc_def0; // arbitrary vendor text
   localparam logic [31:0] VC = 32'h0f1e_2d3c; // arbitrary vendor text
   localparam logic [127:0] THERM = {32'h5, 32'h2, 32'h9, 32'h0}; // thermal leaf words
   typedef struct {
      logic [31:0] leaf;
      logic [31:0] sub;
      logic [127:0] exp;
      logic [3:0] m;
   } pid_row_t;
   logic core_clk, rstn, req_valid, req_ready, busy, resp_valid;
   pid_req_t req;
   logic [63:0] wa, wb, wc, wd;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [255:0] got;
   int fails, total_checks, lat, bcy, answered;
   pid_row_t rows [14];

   // ****************************************
   // design and pipeline model
   // ****************************************
   pid_responder #(.MAX_BASIC(MAXB), .VENDOR_B(VB), .VENDOR_D(VD), .VENDOR_C(VC)) i_dut (
      .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .busy(busy), .resp_valid(resp_valid), .wide_result_a(wa), .result_word_b(wb),
      .result_word_c(wc), .result_word_d(wd), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   pid_core_model i_core (.core_clk(core_clk), .req_ready(req_ready), .busy(busy),
      .resp_valid(resp_valid), .words({wa, wb, wc, wd}), .req_valid(req_valid), .req(req));

   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic print_verdict();
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic flag(input string msg);
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
   endtask
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) flag($sformatf("got %h expected %h", g, e));
   endtask
   // upper halves always zero, low halves compared where the mask asks
   task automatic cmp_quad(input logic [255:0] g, input logic [127:0] e, input logic [3:0] m);
      for (int i = 0; i < 4; i++) begin
         total_checks++;
         if (g[i*64+32 +: 32] !== 32'h0 || (m[i] && g[i*64 +: 32] !== e[i*32 +: 32]))
            flag($sformatf("word %0d got %h expected %h", 3 - i, g[i*64 +: 64], e[i*32 +: 32]));
      end
   endtask
   // one query through the pipeline model
   task automatic ask(input logic [31:0] leaf, input logic [31:0] sub, input bit linger);
      i_core.issue(leaf, sub, linger, got, lat, bcy);
      if (lat > 10) begin
         flag("query not answered");
         print_verdict();
      end
      answered++;
   endtask
   // apb master: setup, access until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      if (n >= 20) begin
         flag("apb access never completed");
         print_verdict();
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fails = 0;
      total_checks = 0;
      answered = 0;
      rows = '{
         '{32'h0, 32'h0, {MAXB, VB, VC, VD}, 4'hf},
         '{32'h1, 32'h0, {32'h1, 32'h0002_0800, 32'h0, 32'h1000_0000}, 4'hf},
         '{32'h4, 32'h0, {32'h0c00_4121, 32'h01c0_003f, 32'h3f, 32'h0}, 4'hf},
         '{32'h4, 32'h1, {32'h0c00_4122, 32'h00c0_003f, 32'h3f, 32'h0}, 4'hf},
         '{32'h4, 32'h2, {32'h0c00_4143, 32'h03c0_003f, 32'h1ff, 32'h2}, 4'hf},
         '{32'h4, 32'h3, 128'h0, 4'hf},
         '{32'h4, 32'h9, 128'h0, 4'hf},
         '{32'h5, 32'h0, {32'h40, 32'h40, 32'h3, 32'h2220}, 4'hf},
         '{32'h6, 32'h0, THERM, 4'he},
         '{32'h7, 32'h0, THERM, 4'he},
         '{32'h8000_0009, 32'h0, THERM, 4'he},
         '{32'h8000_0008, 32'h0, 128'h0, 4'hf},
         '{32'h2, 32'h0, 128'h0, 4'hf},
         '{32'h3, 32'h0, 128'h0, 4'hf}};
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      cmp32({29'h0, req_ready, busy, resp_valid}, 32'h4);
      cmp_quad({wa, wb, wc, wd}, 128'h0, 4'hf);
      // ordinary queries from the table
      for (int i = 0; i < 14; i++) begin
         ask(rows[i].leaf, rows[i].sub, 1'b0);
         cmp_quad(got, rows[i].exp, rows[i].m);
         cmp32(32'(lat), 32'd3);
         cmp32(32'(bcy), 32'd2);
      end
      // strobe kept high while busy is ignored
      ask(32'h1, 32'h0, 1'b1);
      cmp_quad(got, rows[1].exp, rows[1].m);
      cmp32(32'(lat), 32'd3);
      // legacy leaf limit: reset value, writable bit only, hides upper leaves
      apb(1'b0, PID_OFF_MISC, 32'h0);
      cmp32(rd, 32'h0);
      apb(1'b1, PID_OFF_MISC, 32'hffff_ffff);
      apb(1'b0, PID_OFF_MISC, 32'h0);
      cmp32(rd, 32'h0040_0000);
      ask(32'h0, 32'h0, 1'b0);
      cmp_quad(got, {32'h3, VB, VC, VD}, 4'hf);
      apb(1'b1, PID_OFF_MISC, 32'h0);
      ask(32'h0, 32'h0, 1'b0);
      cmp_quad(got, rows[0].exp, 4'h8);
      // status count of answered queries, busy clear when idle
      apb(1'b0, PID_OFF_STAT, 32'h0);
      cmp32(rd, {16'h0, 16'(answered)});
      // unmapped place reads zero with an error
      apb(1'b0, 12'h008, 32'h0);
      cmp32(rd, 32'h0);
      cmp32({31'h0, err}, 32'h1);
      // second reset in mid-run clears words and limit
      apb(1'b1, PID_OFF_MISC, 32'h0040_0000);
      ask(32'h5, 32'h0, 1'b0);
      cmp_quad(got, 128'h0, 4'hf);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      cmp_quad({wa, wb, wc, wd}, 128'h0, 4'hf);
      apb(1'b0, PID_OFF_MISC, 32'h0);
      cmp32(rd, 32'h0);
      print_verdict();
   end
endmodule
